// >>> logic/block_check_gen.sv
`timescale 1ns/1ps
`default_nettype none

module block_check_gen
   import cs_buffer_pkg::*;
(
   input  wire logic [8*CHECK_BYTES-1:0] block_bits,
   output logic      [7:0]               check_byte
);

   // serial crc in send order, first byte and its msb first
   function automatic logic [7:0] crc_over(input logic [8*CHECK_BYTES-1:0] bits);
      logic [7:0] crc;
      logic       fb;
      crc = CHECK_INIT;
      for (int i = 8*CHECK_BYTES-1; i >= 0; i--) begin
         fb  = crc[7] ^ bits[i];
         crc = {crc[6:0], 1'b0} ^ (fb ? CHECK_POLY : 8'h00);
      end
      return crc;
   endfunction

   // combinational check byte
   assign check_byte = crc_over(block_bits);

endmodule
`default_nettype wire

// >>> logic/channel_status_block_buffer.sv
`timescale 1ns/1ps
`default_nettype none

module channel_status_block_buffer
   import cs_buffer_pkg::*;
(
   input  wire logic          mclk,
   input  wire logic          nrst,
   input  wire cp_req_t       cp_req,
   output logic      [7:0]    cp_rdata,
   input  wire logic          two_byte_mode,
   input  wire logic          read_chan_b,
   input  wire logic          copy_inhibit,
   input  wire logic          copy_irq_en,
   output logic               copy_irq,
   input  wire logic          frame_strobe,
   input  wire logic          block_start,
   input  wire logic          hw_mode,
   input  wire logic          hw_serial_sel,
   input  wire logic          serial_cs_in,
   input  wire logic          copy_pin,
   input  wire logic          origin_select_input,
   output logic               cs_bit_a,
   output logic               cs_bit_b,
   output logic               cs_valid
);

   cs_word_t               e_mem [BUF_WORDS];
   cs_word_t               f_mem [BUF_WORDS];
   logic     [7:0]         hw_blk_q [BUF_WORDS];
   logic     [PTR_W-1:0]   ptr_q;
   logic     [7:0]         cp_rdata_q;
   logic     [FRAME_W-1:0] frame_q;
   logic     [FRAME_W-1:0] idx_q;
   logic                   load_q;
   logic                   cs_bit_a_q;
   logic                   cs_bit_b_q;
   logic                   cs_valid_q;
   logic                   copy_q;
   logic     [7:0]         src_a [BUF_WORDS];
   logic     [7:0]         src_b [BUF_WORDS];
   logic     [8*CHECK_BYTES-1:0] chk_in_a;
   logic     [8*CHECK_BYTES-1:0] chk_in_b;
   logic     [7:0]         chk_a;
   logic     [7:0]         chk_b;
   logic                   copy_now;
   logic     [FRAME_W-1:0] frame_now;
   logic                   in_win;
   logic     [WORD_W-1:0]  word;
   logic                   half_b;
   logic                   xfer;

   // map a byte pointer onto a staging word for the current access mode
   function automatic logic [WORD_W-1:0] word_of(input logic [PTR_W-1:0] p, input logic two);
      logic [PTR_W-1:0] off;
      off = p - BUF_BASE;
      return two ? off[WORD_W:1] : off[WORD_W-1:0];
   endfunction

   // pointer lies inside the staging window for the current mode
   function automatic logic window_hit(input logic [PTR_W-1:0] p, input logic two);
      logic [PTR_W-1:0] off;
      off = p - BUF_BASE;
      return (p >= BUF_BASE) && (two ? (off < PTR_W'(2*BUF_WORDS)) : (off < PTR_W'(BUF_WORDS)));
   endfunction

   // pick one bit of a byte by frame index, msb first
   function automatic logic bit_of(input logic [7:0] b, input logic [FRAME_W-1:0] idx);
      return b[3'd7 - idx[2:0]];
   endfunction

   assign in_win = window_hit(ptr_q, two_byte_mode);
   assign word   = word_of(ptr_q, two_byte_mode);
   assign half_b = two_byte_mode & ptr_q[0];
   assign xfer   = (cp_req.wr | cp_req.rd) & ~cp_req.load;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ptr_q <= '0;
      end else if (cp_req.load) begin
         ptr_q <= cp_req.data[PTR_W-1:0];
      end else if (xfer) begin
         ptr_q <= ptr_q + PTR_W'(1);
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < BUF_WORDS; i++) begin
            e_mem[i] <= '0;
         end
      end else if (cp_req.wr && !cp_req.load && in_win) begin
         if (!two_byte_mode) begin
            e_mem[word].chan_a <= cp_req.data;
            e_mem[word].chan_b <= cp_req.data;
         end else if (!half_b) begin
            e_mem[word].chan_a <= cp_req.data;
         end else begin
            e_mem[word].chan_b <= cp_req.data;
         end
      end
   end

   // staging reads, outside the window reads zero
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cp_rdata_q <= 8'h00;
      end else if (cp_req.rd && !cp_req.wr && !cp_req.load) begin
         if (!in_win) begin
            cp_rdata_q <= 8'h00;
         end else if (two_byte_mode) begin
            cp_rdata_q <= half_b ? e_mem[word].chan_b : e_mem[word].chan_a;
         end else begin
            cp_rdata_q <= read_chan_b ? e_mem[word].chan_b : e_mem[word].chan_a;
         end
      end
   end

   assign cp_rdata = cp_rdata_q;

   // frame index of the frame that this strobe opens
   assign frame_now = block_start ? '0 :
                      (frame_q == LAST_FRAME) ? LAST_FRAME : frame_q + FRAME_W'(1);

   // frame counter
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         frame_q <= LAST_FRAME;
      end else if (frame_strobe) begin
         frame_q <= frame_now;
      end
   end

   // serial status input collected one bit per frame
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < BUF_WORDS; i++) begin
            hw_blk_q[i] <= 8'h00;
         end
      end else if (frame_strobe && hw_mode && hw_serial_sel) begin
         hw_blk_q[frame_now[FRAME_W-1:3]][3'd7 - frame_now[2:0]] <= serial_cs_in;
      end
   end

   // source block for the next copy
   always_comb begin
      for (int i = 0; i < BUF_WORDS; i++) begin
         if (!hw_mode) begin
            src_a[i] = e_mem[i].chan_a;
            src_b[i] = e_mem[i].chan_b;
         end else if (hw_serial_sel) begin
            src_a[i] = hw_blk_q[i];
            src_b[i] = hw_blk_q[i];
         end else begin
            src_a[i] = 8'h00;
            src_b[i] = 8'h00;
         end
      end
      // consumer block built from the copy and origin pins
      if (hw_mode && !hw_serial_sel) begin
         src_a[COPY_BYTE][COPY_POS]     = copy_pin;
         src_b[COPY_BYTE][COPY_POS]     = copy_pin;
         src_a[ORIGIN_BYTE][ORIGIN_POS] = origin_select_input;
         src_b[ORIGIN_BYTE][ORIGIN_POS] = origin_select_input;
      end
   end

   // check byte inputs, byte 0 in the top bits
   always_comb begin
      chk_in_a = '0;
      chk_in_b = '0;
      for (int i = 0; i < CHECK_BYTES; i++) begin
         chk_in_a[8*(CHECK_BYTES-i)-1 -: 8] = src_a[i];
         chk_in_b[8*(CHECK_BYTES-i)-1 -: 8] = src_b[i];
      end
   end

   block_check_gen u_check_a (
      .block_bits (chk_in_a),
      .check_byte (chk_a)
   );

   block_check_gen u_check_b (
      .block_bits (chk_in_b),
      .check_byte (chk_b)
   );

   assign copy_now = block_start & ~copy_inhibit;

   // whole block copy into the output buffer
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < BUF_WORDS; i++) begin
            f_mem[i] <= '0;
         end
      end else if (copy_now) begin
         // a skipped boundary leaves the old block whole
         for (int i = 0; i < BUF_WORDS; i++) begin
            f_mem[i].chan_a <= src_a[i];
            f_mem[i].chan_b <= src_b[i];
         end
         // check byte replaces the last byte for professional blocks
         if (src_a[0][FORMAT_POS]) begin
            f_mem[BUF_WORDS-1].chan_a <= chk_a;
         end
         if (src_b[0][FORMAT_POS]) begin
            f_mem[BUF_WORDS-1].chan_b <= chk_b;
         end
      end
   end

   // copy event flag, gated onto the interrupt
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         copy_q <= 1'b0;
      end else begin
         copy_q <= copy_now;
      end
   end

   assign copy_irq = copy_q & copy_irq_en;

   // frame index latched, bits read one cycle later from the fresh block
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         idx_q  <= '0;
         load_q <= 1'b0;
      end else begin
         load_q <= frame_strobe;
         if (frame_strobe) begin
            idx_q <= frame_now;
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cs_bit_a_q <= 1'b0;
         cs_bit_b_q <= 1'b0;
         cs_valid_q <= 1'b0;
      end else begin
         cs_valid_q <= load_q;
         if (load_q) begin
            cs_bit_a_q <= bit_of(f_mem[idx_q[FRAME_W-1:3]].chan_a, idx_q);
            cs_bit_b_q <= bit_of(f_mem[idx_q[FRAME_W-1:3]].chan_b, idx_q);
         end
      end
   end

   assign cs_bit_a = cs_bit_a_q;
   assign cs_bit_b = cs_bit_b_q;
   assign cs_valid = cs_valid_q;

   // checks
   sequence boundary_open_s;
      block_start && !copy_inhibit;
   endsequence

   sequence boundary_shut_s;
      block_start && copy_inhibit;
   endsequence

   copy_event_a: assert property (@(posedge mclk) disable iff (!nrst)
      boundary_open_s ##1 copy_irq_en |-> copy_irq)
      else $error("copy event gave no interrupt");

   inhibit_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
      boundary_shut_s |=> !copy_q)
      else $error("copy taken while inhibited");

   boundary_only_a: assert property (@(posedge mclk) disable iff (!nrst)
      !block_start |=> $stable(f_mem[0]) && $stable(f_mem[BUF_WORDS-1]))
      else $error("output block changed away from block boundary");

   skip_keep_a: assert property (@(posedge mclk) disable iff (!nrst)
      boundary_shut_s |=> f_mem[0] == $past(f_mem[0]) && f_mem[BUF_WORDS-1] == $past(f_mem[BUF_WORDS-1]))
      else $error("inhibited boundary changed output block");

   ptr_step_a: assert property (@(posedge mclk) disable iff (!nrst)
      xfer |=> ptr_q == $past(ptr_q) + PTR_W'(1))
      else $error("pointer did not advance");

   one_byte_wr_a: assert property (@(posedge mclk) disable iff (!nrst)
      cp_req.wr && !cp_req.load && in_win && !two_byte_mode |=>
      e_mem[$past(word)].chan_a == $past(cp_req.data) && e_mem[$past(word)].chan_b == $past(cp_req.data))
      else $error("one byte write missed a half");

   two_byte_rd_a: assert property (@(posedge mclk) disable iff (!nrst)
      cp_req.rd && !cp_req.wr && !cp_req.load && in_win && two_byte_mode && !half_b |=>
      cp_rdata == e_mem[$past(word)].chan_a)
      else $error("two byte read did not give channel a first");

   one_byte_rd_a: assert property (@(posedge mclk) disable iff (!nrst)
      cp_req.rd && !cp_req.wr && !cp_req.load && in_win && !two_byte_mode && read_chan_b |=>
      cp_rdata == e_mem[$past(word)].chan_b)
      else $error("one byte read ignored channel select");

   check_byte_a: assert property (@(posedge mclk) disable iff (!nrst)
      copy_now && src_a[0][FORMAT_POS] |=> f_mem[BUF_WORDS-1].chan_a == $past(chk_a))
      else $error("check byte not inserted");

   msb_first_a: assert property (@(posedge mclk) disable iff (!nrst)
      frame_strobe && block_start ##2 cs_valid |->
      cs_bit_a == f_mem[0].chan_a[FORMAT_POS] && cs_bit_b == f_mem[0].chan_b[FORMAT_POS])
      else $error("first status bit is not byte 0 msb");

endmodule
`default_nettype wire

// >>> logic/cs_buffer_pkg.sv
package cs_buffer_pkg;

   // control port pointer and buffer window
   localparam int          PTR_W         = 7;
   localparam logic [6:0]  BUF_BASE      = 7'h20;
   localparam int          BUF_WORDS     = 24;
   localparam int          WORD_W        = 5;
   localparam int          CHECK_BYTES   = BUF_WORDS - 1;

   // frame timebase
   localparam int          FRAMES        = 192;
   localparam int          FRAME_W       = 8;
   localparam logic [7:0]  LAST_FRAME    = 8'hbf;

   // status byte fields, bit positions within a stored byte
   localparam int          FORMAT_POS    = 7;
   localparam int          COPY_POS      = 5;
   localparam int          COPY_BYTE     = 0;
   localparam int          ORIGIN_POS    = 0;
   localparam int          ORIGIN_BYTE   = 1;

   // check byte generator, polynomial x^8+x^4+x^3+x^2+1
   localparam logic [7:0]  CHECK_POLY    = 8'h1d;
   localparam logic [7:0]  CHECK_INIT    = 8'hff;

   // one staging or output word, channel a in the upper byte
   typedef struct packed {
      logic [7:0] chan_a;
      logic [7:0] chan_b;
   } cs_word_t;

   // one control port byte transfer
   typedef struct packed {
      logic       load;
      logic       wr;
      logic       rd;
      logic [7:0] data;
   } cp_req_t;

endpackage

// >>> tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none

// control port host, one byte per strobe, strobe held for one cycle
module host_model
   import cs_buffer_pkg::*;
(
   input  wire logic       mclk,
   output var  cp_req_t    cp_req,
   input  wire logic [7:0] cp_rdata
);

   // idle control port from time zero
   initial cp_req = '0;

   // one transfer: raise after an edge, release after the taking edge
   task automatic put(input logic ld, input logic w, input logic r, input logic [7:0] v);
      @(posedge mclk) #1 cp_req = '{load: ld, wr: w, rd: r, data: v};
      @(posedge mclk) #1 cp_req = '0;
   endtask

   // pointer load ahead of a burst
   task automatic load(input logic [7:0] p);
      put(1'b1, 1'b0, 1'b0, p);
   endtask

   // host sends one byte, a or b by pointer in two-byte mode
   task automatic wr(input logic [7:0] v);
      put(1'b0, 1'b1, 1'b0, v);
   endtask

   // read byte taken at the edge where the strobe is released
   task automatic rd(output logic [7:0] v);
      put(1'b0, 1'b0, 1'b1, 8'h00);
      v = cp_rdata;
   endtask

endmodule

`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
   $display("Error at %0t: got %h exp %h", $time, g, e); end end

module tb;
   import cs_buffer_pkg::*;

   logic       mclk, nrst, two_byte_mode, read_chan_b, copy_inhibit, copy_irq_en, copy_irq;
   logic       frame_strobe, block_start, hw_mode, hw_serial_sel, serial_cs_in, copy_pin;
   logic       origin_select_input, cs_bit_a, cs_bit_b, cs_valid;
   cp_req_t    cp_req;
   logic [7:0] cp_rdata, d;
   logic [7:0] sa[24], sb[24], xa[24], xb[24], ga[24], gb[24], sx[24];
   int         errors, num_checks;

   channel_status_block_buffer i_channel_status_block_buffer (.mclk, .nrst, .cp_req, .cp_rdata,
      .two_byte_mode, .read_chan_b, .copy_inhibit, .copy_irq_en, .copy_irq, .frame_strobe,
      .block_start, .hw_mode, .hw_serial_sel, .serial_cs_in, .copy_pin, .origin_select_input,
      .cs_bit_a, .cs_bit_b, .cs_valid);

   host_model i_host_model (.mclk, .cp_req, .cp_rdata);

   // 250 mhz clock
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // level controls driven from one place
   task automatic set_mode(input logic two, input logic chb, input logic inh, input logic en,
                           input logic hw, input logic sel, input logic cp, input logic org);
      two_byte_mode       = two;
      read_chan_b         = chb;
      copy_inhibit        = inh;
      copy_irq_en         = en;
      hw_mode             = hw;
      hw_serial_sel       = sel;
      copy_pin            = cp;
      origin_select_input = org;
   endtask

   // verdict and end of run
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // expected check byte over bytes 0..22, msb first
   function automatic logic [7:0] crc8(input logic [7:0] v[24]);
      logic [7:0] c;
      c = CHECK_INIT;
      for (int i = 0; i < CHECK_BYTES; i++)
         for (int k = 7; k >= 0; k--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i][k]) ? CHECK_POLY : 8'h00);
      return c;
   endfunction

   // one full block of frames, capturing both status streams
   task automatic run_block(input logic irq_exp);
      for (int n = 0; n < FRAMES; n++) begin
         @(posedge mclk) #1 frame_strobe = 1'b1;
         block_start = (n == 0);
         serial_cs_in = sx[n >> 3][7 - (n & 7)];
         @(posedge mclk) #1 frame_strobe = 1'b0;
         block_start = 1'b0;
         // interrupt one cycle after a copy
         if (n == 0) `CHK(copy_irq, irq_exp)
         @(posedge mclk) #1;
         if (n == 0) `CHK(copy_irq, 1'b0)
         `CHK(cs_valid, 1'b1)
         ga[n >> 3][7 - (n & 7)] = cs_bit_a;
         gb[n >> 3][7 - (n & 7)] = cs_bit_b;
      end
      for (int i = 0; i < BUF_WORDS; i++) begin
         `CHK(ga[i], xa[i])
         `CHK(gb[i], xb[i])
      end
   endtask

   // watchdog
   initial begin
      #60000;
      errors++;
      summarize();
   end

   // main sequence
   initial begin
      nrst = 1'b0;
      frame_strobe = 1'b0;
      block_start = 1'b0;
      serial_cs_in = 1'b0;
      sx = '{default: 8'h00};
      set_mode(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      errors = 0;
      num_checks = 0;
      repeat (16) @(posedge mclk);
      #1 nrst = 1'b1;
      `CHK(cp_rdata, 8'h00)
      `CHK(copy_irq, 1'b0)
      // two-byte burst fill of the staging buffer
      i_host_model.load({1'b0, BUF_BASE});
      for (int i = 0; i < BUF_WORDS; i++) begin
         sa[i] = 8'h10 + 8'(i);
         sb[i] = 8'h40 + 8'(i);
         i_host_model.wr(sa[i]);
         i_host_model.wr(sb[i]);
      end
      i_host_model.load({1'b0, BUF_BASE});
      for (int i = 0; i < BUF_WORDS; i++) begin
         i_host_model.rd(d);
         `CHK(d, sa[i])
         i_host_model.rd(d);
         `CHK(d, sb[i])
      end
      set_mode(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      i_host_model.load(8'h21);
      i_host_model.wr(8'h5a);
      sa[1] = 8'h5a;
      sb[1] = 8'h5a;
      // one-byte burst reads, channel a selected then channel b
      i_host_model.load(8'h21);
      i_host_model.rd(d);
      `CHK(d, 8'h5a)
      i_host_model.rd(d);
      `CHK(d, sa[2])
      set_mode(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      i_host_model.load(8'h21);
      i_host_model.rd(d);
      `CHK(d, 8'h5a)
      i_host_model.rd(d);
      `CHK(d, sb[2])
      i_host_model.load(8'h38);
      i_host_model.rd(d);
      `CHK(d, 8'h00)
      set_mode(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      i_host_model.load(8'h22);
      i_host_model.rd(d);
      `CHK(d, 8'h5a)
      i_host_model.rd(d);
      `CHK(d, 8'h5a)
      // block copy with interrupt
      set_mode(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      xa = sa;
      xb = sb;
      run_block(1'b1);
      // inhibit around a session, old block must be resent
      set_mode(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      i_host_model.load({1'b0, BUF_BASE});
      // host sets the copy bit of channel a byte 0 itself
      i_host_model.wr(8'h33);
      i_host_model.wr(8'h44);
      sa[0] = 8'h33;
      sb[0] = 8'h44;
      run_block(1'b0);
      set_mode(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      xa = sa;
      xb = sb;
      run_block(1'b1);
      // professional channel a gets its check byte
      i_host_model.load({1'b0, BUF_BASE});
      i_host_model.wr(8'h80);
      sa[0] = 8'h80;
      xa = sa;
      xa[CHECK_BYTES] = crc8(sa);
      run_block(1'b1);
      // hardware pin mode, interrupt disabled
      set_mode(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
      xa = '{default: 8'h00};
      xa[COPY_BYTE][COPY_POS] = 1'b1;
      xa[ORIGIN_BYTE][ORIGIN_POS] = 1'b1;
      xb = xa;
      run_block(1'b0);
      // hardware serial input, first block copies the still empty collector
      for (int i = 0; i < BUF_WORDS; i++)
         sx[i] = 8'h20 + 8'(i);
      sx[0] = 8'h81;
      set_mode(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
      xa = '{default: 8'h00};
      xb = xa;
      run_block(1'b0);
      // collected professional block gets its check byte on both channels
      xa = sx;
      xa[CHECK_BYTES] = crc8(sx);
      xb = xa;
      run_block(1'b0);
      summarize();
   end

endmodule

`default_nettype wire
